// ---- common/msr_pkg.sv ----
// shared constants, command codes and carriers for the status register bank
package msr_pkg;

	localparam int REG_W  = 16;
	localparam int DATA_W = 15;
	localparam int SETS   = 8;
	localparam int SET_W  = 3;

	// register set indices on the command port
	localparam logic [2:0] SET_OPER = 3'h0;
	localparam logic [2:0] SET_LOW  = 3'h1;
	localparam logic [2:0] SET_MEAS = 3'h2;
	localparam logic [2:0] SET_SENS = 3'h3;
	localparam logic [2:0] SET_TRIG = 3'h4;
	localparam logic [2:0] SET_HIGH = 3'h5;
	localparam logic [2:0] SET_QUES = 3'h6;
	localparam logic [2:0] SET_CAL  = 3'h7;

	// operation summary bit positions
	localparam int OPER_CAL_BIT  = 0;
	localparam int OPER_MEAS_BIT = 4;
	localparam int OPER_TRIG_BIT = 5;
	localparam int OPER_SENS_BIT = 10;
	localparam int OPER_LOW_BIT  = 11;
	localparam int OPER_HIGH_BIT = 12;

	// data quality summary bit positions
	localparam int QUES_POW_BIT  = 3;
	localparam int QUES_CAL_BIT  = 8;
	localparam int QUES_TEST_BIT = 9;

	// channel A sits at bit 1, so a channel vector starts there
	localparam int CHAN_LSB = 1;

	// preset and reset values of enable and filters
	localparam logic [14:0] PRE_ZEROS = 15'h0000;
	localparam logic [14:0] PRE_ONES  = 15'h7FFF;

	typedef enum logic [2:0] {
		MSR_K_COND   = 3'b000,
		MSR_K_EVENT  = 3'b001,
		MSR_K_ENABLE = 3'b010,
		MSR_K_RISE   = 3'b011,
		MSR_K_FALL   = 3'b100,
		MSR_K_PRESET = 3'b101
	} msr_kind_type;

	typedef struct packed {
		logic               valid;
		logic               write;
		logic [2:0]         set;
		msr_kind_type       kind;
		logic [15:0]        data;
	} msr_cmd_type;

	typedef struct packed {
		logic               valid;
		logic               err;
		logic [15:0]        data;
	} msr_rsp_type;

	// per channel / window limit test results: A, B, upper win, lower win
	typedef struct packed {
		logic [3:0]         done;
		logic [3:0]         low_en;
		logic [3:0]         low_fail;
		logic [3:0]         high_en;
		logic [3:0]         high_fail;
	} msr_limit_type;

endpackage

// ---- rtl/msr_sticky.sv ----
// sticky condition bits: set by one event, cleared by another
module msr_sticky #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             arst_n,
	// events
	input  wire logic [WIDTH-1:0] set,
	input  wire logic [WIDTH-1:0] clr,
	// state
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] next_q;

	// a set in the clearing cycle wins
	assign next_q = (q & ~clr) | set;

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			q <= '0;
		else
			q <= next_q;
	end

	chk_sticky_set_wins : assert property (@(posedge clk_sys) disable iff (!arst_n)
		(set != '0) |=> ((q & $past(set)) == $past(set)))
		else $error("sticky bit lost a set event");

endmodule

// ---- rtl/msr_regset.sv ----
// one status register set: condition edges, filters, event latch, enable
module msr_regset #(
	parameter logic [14:0] EN_PRESET   = msr_pkg::PRE_ONES,
	parameter logic [14:0] RISE_PRESET = msr_pkg::PRE_ONES,
	parameter logic [14:0] FALL_PRESET = msr_pkg::PRE_ZEROS
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	// condition from the block
	input  wire logic [14:0] cond,
	// command strobes
	input  wire logic        wr_enable,
	input  wire logic        wr_rise,
	input  wire logic        wr_fall,
	input  wire logic [14:0] wr_data,
	input  wire logic        rd_event,
	input  wire logic        preset,
	// register contents
	output logic      [14:0] enable,
	output logic      [14:0] rising_filter,
	output logic      [14:0] falling_filter,
	output logic      [14:0] event_q,
	output logic             summary
);

	logic [14:0] cond_q;
	logic [14:0] set_mask;
	logic [14:0] next_event;

	// event clear value, declared ahead of its first use
	localparam logic [14:0] PRE_ZEROS_L = msr_pkg::PRE_ZEROS;

	assign set_mask   = (cond & ~cond_q & rising_filter)
		| (~cond & cond_q & falling_filter);
	assign next_event = (rd_event ? PRE_ZEROS_L : event_q) | set_mask;
	assign summary    = |(event_q & enable);

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cond_q         <= msr_pkg::PRE_ZEROS;
			event_q        <= msr_pkg::PRE_ZEROS;
			enable         <= EN_PRESET;
			rising_filter  <= RISE_PRESET;
			falling_filter <= FALL_PRESET;
		end
		else
		begin
			cond_q  <= cond;
			event_q <= next_event;
			enable         <= preset ? EN_PRESET : (wr_enable ? wr_data : enable);
			rising_filter  <= preset ? RISE_PRESET : (wr_rise ? wr_data : rising_filter);
			falling_filter <= preset ? FALL_PRESET : (wr_fall ? wr_data : falling_filter);
		end
	end

	chk_rise_latches_event : assert property (@(posedge clk_sys) disable iff (!arst_n)
		(((cond & ~cond_q & rising_filter) != '0))
		|=> ((event_q & $past(cond & ~cond_q & rising_filter)) != '0))
		else $error("filtered rising edge did not latch");

	chk_event_read_clears : assert property (@(posedge clk_sys) disable iff (!arst_n)
		(rd_event && set_mask == '0) |=> (event_q == '0))
		else $error("event read did not clear");

	chk_filter_write_stores : assert property (@(posedge clk_sys) disable iff (!arst_n)
		(wr_rise && !preset) |=> (rising_filter == $past(wr_data)))
		else $error("rising filter write not stored");

endmodule

// ---- rtl/msr_top.sv ----
// status register bank of a two-channel meter, reached by status commands
//
// Notes on behaviour
// - a failed lower limit test sets the low-limit-fail bit of channel A, B, upper or lower window.
// - a limit-fail bit clears only when a measurement ends with its test enabled and passing.
// - a failed upper limit test sets the matching high-limit-fail bit at weights 2, 4, 8 or 16.
// - the measuring bits 1 and 2 follow each channel's measurement in progress.
// - the sensor-read bits are high only while the sensor calibration memory is being read.
// - trigger bits set on entering wait-for-trigger and clear on returning to idle.
// - preset loads enable zeros for operation and data quality sets, ones elsewhere; rising ones; falling zeros.
// - preset leaves conditions and events alone, and bit 15 of every register reads zero.
// - data quality bit 3 is the OR of the enabled power set outputs.
// - data quality bit 8 is the OR of the enabled calibration quality set outputs.
// - data quality bit 9 sets on a failed power-on self-test and clears on a pass.
// - a zeroing or calibration error event sets that channel's calibration quality bit.
// - a later zero or calibration that ends without error clears that bit.
// - a filter write keeps the low 15 bits and forces bit 15 to zero.
// - reading an event register returns its bits and clears it.
// - operation summary bits 4, 5, 10, 11, 12 carry measuring, trigger, sensor, low and high fail.
module msr_top (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  arst_n,
	// status command port
	input  wire msr_pkg::msr_cmd_type  cmd,
	output msr_pkg::msr_rsp_type       rsp,
	// limit tests
	input  wire msr_pkg::msr_limit_type limit,
	// channel activity, A at bit 0
	input  wire logic [1:0]            meas_busy,
	input  wire logic [1:0]            sensor_reading,
	input  wire logic [1:0]            trig_enter_wait,
	input  wire logic [1:0]            trig_enter_idle,
	// calibration quality events
	input  wire logic [1:0]            cal_error,
	input  wire logic [1:0]            cal_success,
	// summaries of sets kept elsewhere
	input  wire logic                  calibrating_summary,
	input  wire logic                  power_summary,
	// power-on self-test result pulses
	input  wire logic                  selftest_fail,
	input  wire logic                  selftest_pass,
	// summaries towards the status byte
	output logic                       operation_summary,
	output logic                       data_quality_out
);

	localparam int SETS = msr_pkg::SETS;

	// sticky condition sources
	logic [3:0]  low_set;
	logic [3:0]  low_clr;
	logic [3:0]  high_set;
	logic [3:0]  high_clr;
	logic [3:0]  low_fail;
	logic [3:0]  high_fail;
	logic [1:0]  trig_wait;
	logic [1:0]  cal_bad;
	logic        test_bad;

	// per-set condition and contents
	logic [14:0] cond      [SETS];
	logic [14:0] enable    [SETS];
	logic [14:0] rise_f    [SETS];
	logic [14:0] fall_f    [SETS];
	logic [14:0] event_q   [SETS];
	logic [SETS-1:0] summ;

	// command decode
	logic        cmd_rd;
	logic        cmd_wr;
	logic        do_preset;
	logic        kind_bad;
	logic [14:0] rd_data;
	logic        rd_err;

	// limit tests only count on a finished measurement with the test enabled
	assign low_set  = limit.done & limit.low_en & limit.low_fail;
	assign low_clr  = limit.done & limit.low_en & ~limit.low_fail;
	assign high_set = limit.done & limit.high_en & limit.high_fail;
	assign high_clr = limit.done & limit.high_en & ~limit.high_fail;

	msr_sticky #(
		.WIDTH (4)
	) u_low (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.set     (low_set),
		.clr     (low_clr),
		.q       (low_fail)
	);

	msr_sticky #(
		.WIDTH (4)
	) u_high (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.set     (high_set),
		.clr     (high_clr),
		.q       (high_fail)
	);

	msr_sticky #(
		.WIDTH (2)
	) u_trig (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.set     (trig_enter_wait),
		.clr     (trig_enter_idle),
		.q       (trig_wait)
	);

	msr_sticky #(
		.WIDTH (2)
	) u_cal (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.set     (cal_error),
		.clr     (cal_success),
		.q       (cal_bad)
	);

	msr_sticky #(
		.WIDTH (1)
	) u_test (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.set     (selftest_fail),
		.clr     (selftest_pass),
		.q       (test_bad)
	);

	// condition vectors; channel bits start at bit 1
	always_comb
	begin
		for (int s = 0; s < SETS; s++)
			cond[s] = msr_pkg::PRE_ZEROS;
		cond[msr_pkg::SET_LOW][4:1]  = low_fail;
		cond[msr_pkg::SET_HIGH][4:1] = high_fail;
		cond[msr_pkg::SET_MEAS][2:1] = meas_busy;
		cond[msr_pkg::SET_SENS][2:1] = sensor_reading;
		cond[msr_pkg::SET_TRIG][2:1] = trig_wait;
		cond[msr_pkg::SET_CAL][2:1]  = cal_bad;
		cond[msr_pkg::SET_OPER][msr_pkg::OPER_CAL_BIT]  = calibrating_summary;
		cond[msr_pkg::SET_OPER][msr_pkg::OPER_MEAS_BIT] = summ[msr_pkg::SET_MEAS];
		cond[msr_pkg::SET_OPER][msr_pkg::OPER_TRIG_BIT] = summ[msr_pkg::SET_TRIG];
		cond[msr_pkg::SET_OPER][msr_pkg::OPER_SENS_BIT] = summ[msr_pkg::SET_SENS];
		cond[msr_pkg::SET_OPER][msr_pkg::OPER_LOW_BIT]  = summ[msr_pkg::SET_LOW];
		cond[msr_pkg::SET_OPER][msr_pkg::OPER_HIGH_BIT] = summ[msr_pkg::SET_HIGH];
		// power set lives outside; only its summary arrives here
		cond[msr_pkg::SET_QUES][msr_pkg::QUES_POW_BIT]  = power_summary;
		cond[msr_pkg::SET_QUES][msr_pkg::QUES_CAL_BIT]  = summ[msr_pkg::SET_CAL];
		cond[msr_pkg::SET_QUES][msr_pkg::QUES_TEST_BIT] = test_bad;
	end

	// command decode; preset ignores the set field
	assign cmd_rd    = cmd.valid && !cmd.write;
	assign cmd_wr    = cmd.valid && cmd.write;
	assign do_preset = cmd_wr && cmd.kind == msr_pkg::MSR_K_PRESET;
	assign kind_bad  = cmd.kind > msr_pkg::MSR_K_PRESET;

	generate
		for (genvar g = 0; g < SETS; g++)
		begin : g_set
			localparam bit TOP = (g == msr_pkg::SET_OPER) || (g == msr_pkg::SET_QUES);
			logic sel;
			assign sel = cmd.set == 3'(g);
			msr_regset #(
				.EN_PRESET   (TOP ? msr_pkg::PRE_ZEROS : msr_pkg::PRE_ONES),
				.RISE_PRESET (msr_pkg::PRE_ONES),
				.FALL_PRESET (msr_pkg::PRE_ZEROS)
			) u_set (
				.clk_sys        (clk_sys),
				.arst_n         (arst_n),
				.cond           (cond[g]),
				.wr_enable      (cmd_wr && sel && cmd.kind == msr_pkg::MSR_K_ENABLE),
				.wr_rise        (cmd_wr && sel && cmd.kind == msr_pkg::MSR_K_RISE),
				.wr_fall        (cmd_wr && sel && cmd.kind == msr_pkg::MSR_K_FALL),
				.wr_data        (cmd.data[14:0]),
				.rd_event       (cmd_rd && sel && cmd.kind == msr_pkg::MSR_K_EVENT),
				.preset         (do_preset),
				.enable         (enable[g]),
				.rising_filter  (rise_f[g]),
				.falling_filter (fall_f[g]),
				.event_q        (event_q[g]),
				.summary        (summ[g])
			);
		end
	endgenerate

	// read selection; the event read takes the value before its clear
	always_comb
	begin
		rd_data = msr_pkg::PRE_ZEROS;
		rd_err  = 1'b0;
		unique case (cmd.kind)
			msr_pkg::MSR_K_COND:   rd_data = cond[cmd.set];
			msr_pkg::MSR_K_EVENT:  rd_data = event_q[cmd.set];
			msr_pkg::MSR_K_ENABLE: rd_data = enable[cmd.set];
			msr_pkg::MSR_K_RISE:   rd_data = rise_f[cmd.set];
			msr_pkg::MSR_K_FALL:   rd_data = fall_f[cmd.set];
			msr_pkg::MSR_K_PRESET: rd_err  = 1'b1;
			default:               rd_err  = 1'b1;
		endcase
	end

	// conditions and events cannot be written
	logic wr_err;
	assign wr_err = kind_bad || cmd.kind == msr_pkg::MSR_K_COND
		|| cmd.kind == msr_pkg::MSR_K_EVENT;

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rsp               <= '0;
			operation_summary <= 1'b0;
			data_quality_out  <= 1'b0;
		end
		else
		begin
			rsp.valid         <= cmd.valid;
			rsp.err           <= cmd.valid && (cmd.write ? wr_err : rd_err);
			rsp.data          <= cmd_rd ? {1'b0, rd_data} : 16'h0000;
			operation_summary <= summ[msr_pkg::SET_OPER];
			data_quality_out  <= summ[msr_pkg::SET_QUES];
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	sequence s_preset;
		cmd.valid && cmd.write && cmd.kind == msr_pkg::MSR_K_PRESET;
	endsequence

	sequence s_event_read(int s);
		cmd.valid && !cmd.write && cmd.kind == msr_pkg::MSR_K_EVENT && cmd.set == s;
	endsequence

	chk_low_fail_sets : assert property (
		(low_set != 4'h0) |=> ((low_fail & $past(low_set)) == $past(low_set)))
		else $error("low limit fail not set");

	chk_limit_clear_cause : assert property (
		((~low_fail & $past(low_fail)) & ~$past(low_clr)) == 4'h0
		&& ((~high_fail & $past(high_fail)) & ~$past(high_clr)) == 4'h0)
		else $error("limit fail bit cleared without a passing test");

	chk_high_fail_sets : assert property (
		(high_set != 4'h0) |=> ((high_fail & $past(high_set)) == $past(high_set)))
		else $error("high limit fail not set");

	chk_meas_follows : assert property (
		cond[msr_pkg::SET_MEAS] == {12'h000, meas_busy, 1'b0})
		else $error("measuring condition wrong");

	chk_sense_follows : assert property (
		cond[msr_pkg::SET_SENS] == {12'h000, sensor_reading, 1'b0})
		else $error("sensor read condition wrong");

	chk_trig_wait_idle : assert property (
		(trig_enter_wait[1] ##1 !trig_enter_idle[1]) |-> cond[msr_pkg::SET_TRIG][2])
		else $error("trigger bit not set after wait");

	chk_preset_values : assert property (
		s_preset |=> (enable[msr_pkg::SET_OPER] == msr_pkg::PRE_ZEROS
		&& enable[msr_pkg::SET_LOW] == msr_pkg::PRE_ONES
		&& rise_f[msr_pkg::SET_QUES] == msr_pkg::PRE_ONES
		&& fall_f[msr_pkg::SET_CAL] == msr_pkg::PRE_ZEROS))
		else $error("preset values wrong");

	chk_preset_keeps_events : assert property (
		(s_preset and (cond[msr_pkg::SET_LOW] == $past(cond[msr_pkg::SET_LOW])))
		|=> ((event_q[msr_pkg::SET_LOW] & $past(event_q[msr_pkg::SET_LOW]))
		== $past(event_q[msr_pkg::SET_LOW])))
		else $error("preset disturbed an event register");

	chk_bit15_zero : assert property (
		rsp.valid |-> !rsp.data[15])
		else $error("bit 15 read as one");

	chk_power_summary : assert property (
		cond[msr_pkg::SET_QUES][msr_pkg::QUES_POW_BIT] == power_summary)
		else $error("power summary bit wrong");

	chk_cal_summary : assert property (
		cond[msr_pkg::SET_QUES][msr_pkg::QUES_CAL_BIT]
		== |(event_q[msr_pkg::SET_CAL] & enable[msr_pkg::SET_CAL]))
		else $error("calibration summary bit wrong");

	chk_selftest_bit : assert property (
		(selftest_fail ##1 !selftest_pass) |-> cond[msr_pkg::SET_QUES][msr_pkg::QUES_TEST_BIT])
		else $error("self-test bit not set");

	chk_cal_quality : assert property (
		cal_error[0] |=> cal_bad[0])
		else $error("calibration quality bit not set");

	chk_cal_clear : assert property (
		(cal_success[0] && !cal_error[0]) |=> !cal_bad[0])
		else $error("calibration quality bit not cleared");

	chk_event_read_data : assert property (
		s_event_read(1) |=> (rsp.data[14:0] == $past(event_q[msr_pkg::SET_LOW])))
		else $error("event read returned wrong data");

	chk_oper_map : assert property (
		cond[msr_pkg::SET_OPER][msr_pkg::OPER_LOW_BIT] == summ[msr_pkg::SET_LOW]
		&& cond[msr_pkg::SET_OPER][msr_pkg::OPER_HIGH_BIT] == summ[msr_pkg::SET_HIGH]
		&& cond[msr_pkg::SET_OPER][msr_pkg::OPER_TRIG_BIT] == summ[msr_pkg::SET_TRIG])
		else $error("operation summary mapping wrong");

endmodule

// ---- tb/msr_host.sv ----
// host side model: issues one status command and collects the answer
module msr_host (
	// clock
	input  wire logic                 clk_sys,
	// command port
	output msr_pkg::msr_cmd_type      cmd,
	input  wire msr_pkg::msr_rsp_type rsp
);
	timeunit 1ns;
	timeprecision 1ps;

	initial cmd = '0;

	task automatic access(
		input  logic        wr,
		input  logic [2:0]  set,
		input  logic [2:0]  kind,
		input  logic [15:0] data,
		output logic [15:0] rdata,
		output logic        err,
		output logic        ok
	);
		int n;
		@(posedge clk_sys);
		#1;
		cmd.write = wr;
		cmd.set   = set;
		cmd.kind  = msr_pkg::msr_kind_type'(kind);
		cmd.data  = data;
		cmd.valid = 1'b1;
		@(posedge clk_sys);
		#1;
		cmd.valid = 1'b0;
		// a released word must not look like the last value
		cmd.data  = ~data;
		n = 0;
		while (rsp.valid !== 1'b1 && n < 3)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		ok    = (rsp.valid === 1'b1);
		rdata = rsp.data;
		err   = rsp.err;
	endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the status register bank
`define CHK(e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %s exp %h got %h", what, e, g); end end

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic        wr;
		logic [2:0]  set;
		logic [2:0]  kind;
		logic [15:0] data;
		logic [15:0] exp;
		logic        err;
	} msr_row_type;

	logic                   clk_sys = 1'b0;
	logic                   arst_n  = 1'b0;
	msr_pkg::msr_cmd_type   cmd;
	msr_pkg::msr_rsp_type   rsp;
	msr_pkg::msr_limit_type limit = '0;
	logic [1:0]             meas_busy = 2'h0;
	logic [1:0]             sensor_reading = 2'h0;
	logic [1:0]             trig_enter_wait = 2'h0;
	logic [1:0]             trig_enter_idle = 2'h0;
	logic [1:0]             cal_error = 2'h0;
	logic [1:0]             cal_success = 2'h0;
	logic                   calibrating_summary = 1'b0;
	logic                   power_summary = 1'b0;
	logic                   selftest_fail = 1'b0;
	logic                   selftest_pass = 1'b0;
	logic                   operation_summary;
	logic                   data_quality_out;
	int                     n_fail = 0;
	int                     n_tests = 0;
	string                  what;

	// kinds: 0 cond, 1 event, 2 enable, 3 rising, 4 falling, 5 preset
	msr_row_type rows [18] = '{
		'{1'b0, 3'h0, 3'h2, 16'h0000, 16'h0000, 1'b0},
		'{1'b0, 3'h1, 3'h2, 16'h0000, 16'h7FFF, 1'b0},
		'{1'b0, 3'h6, 3'h3, 16'h0000, 16'h7FFF, 1'b0},
		'{1'b0, 3'h7, 3'h4, 16'h0000, 16'h0000, 1'b0},
		'{1'b0, 3'h6, 3'h2, 16'h0000, 16'h0000, 1'b0},
		'{1'b1, 3'h1, 3'h2, 16'hFFFF, 16'h0000, 1'b0},
		'{1'b0, 3'h1, 3'h2, 16'h0000, 16'h7FFF, 1'b0},
		'{1'b1, 3'h2, 3'h4, 16'h8005, 16'h0000, 1'b0},
		'{1'b0, 3'h2, 3'h4, 16'h0000, 16'h0005, 1'b0},
		'{1'b1, 3'h1, 3'h0, 16'h0002, 16'h0000, 1'b1},
		'{1'b0, 3'h1, 3'h5, 16'h0000, 16'h0000, 1'b1},
		'{1'b0, 3'h1, 3'h6, 16'h0000, 16'h0000, 1'b1},
		'{1'b1, 3'h0, 3'h3, 16'h0000, 16'h0000, 1'b0},
		'{1'b0, 3'h0, 3'h3, 16'h0000, 16'h0000, 1'b0},
		'{1'b1, 3'h4, 3'h5, 16'h0000, 16'h0000, 1'b0},
		'{1'b0, 3'h0, 3'h3, 16'h0000, 16'h7FFF, 1'b0},
		'{1'b0, 3'h2, 3'h4, 16'h0000, 16'h0000, 1'b0},
		'{1'b0, 3'h1, 3'h2, 16'h0000, 16'h7FFF, 1'b0}
	};

	always #5 clk_sys = ~clk_sys;

	msr_top u_msr_top (
		.clk_sys            (clk_sys),
		.arst_n             (arst_n),
		.cmd                (cmd),
		.rsp                (rsp),
		.limit              (limit),
		.meas_busy          (meas_busy),
		.sensor_reading     (sensor_reading),
		.trig_enter_wait    (trig_enter_wait),
		.trig_enter_idle    (trig_enter_idle),
		.cal_error          (cal_error),
		.cal_success        (cal_success),
		.calibrating_summary(calibrating_summary),
		.power_summary      (power_summary),
		.selftest_fail      (selftest_fail),
		.selftest_pass      (selftest_pass),
		.operation_summary  (operation_summary),
		.data_quality_out   (data_quality_out)
	);

	msr_host u_msr_host (
		.clk_sys(clk_sys),
		.cmd    (cmd),
		.rsp    (rsp)
	);

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// one command, then answer presence, error flag and data
	task automatic chk_reg(input logic wr, input logic [2:0] set, input logic [2:0] kind,
		input logic [15:0] data, input logic [15:0] exp, input logic exp_err);
		logic [15:0] rdata;
		logic        err;
		logic        ok;
		u_msr_host.access(wr, set, kind, data, rdata, err, ok);
		what = $sformatf("set%0d kind%0d answer", set, kind);
		`CHK(1'b1, ok)
		what = $sformatf("set%0d kind%0d err", set, kind);
		`CHK(exp_err, err)
		// data of a refused unknown kind is left open
		if (!exp_err || kind == 3'h5)
		begin
			what = $sformatf("set%0d kind%0d data", set, kind);
			`CHK(exp, rdata)
		end
	endtask

	task automatic chk_bit(input string nm, input logic exp, input logic got);
		what = nm;
		`CHK(exp, got)
	endtask

	task automatic give_verdict;
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		#200000;
		n_fail++;
		give_verdict;
	end

	initial
	begin
		repeat (20) @(posedge clk_sys);
		#1;
		arst_n = 1'b1;
		foreach (rows[i])
			chk_reg(rows[i].wr, rows[i].set, rows[i].kind, rows[i].data, rows[i].exp,
				rows[i].err);
		$display("test register table done");

		// channel A lower fail, lower window upper fail
		limit.done = 4'h9;
		limit.low_en = 4'h1;
		limit.low_fail = 4'h1;
		limit.high_en = 4'h8;
		limit.high_fail = 4'h8;
		tick(1);
		limit = '0;
		tick(4);
		chk_reg(1'b0, msr_pkg::SET_OPER, 3'h0, 16'h0, 16'h1800, 1'b0);
		chk_reg(1'b1, msr_pkg::SET_OPER, 3'h2, 16'h0800, 16'h0, 1'b0);
		tick(3);
		chk_bit("operation summary", 1'b1, operation_summary);
		chk_reg(1'b0, msr_pkg::SET_LOW, 3'h0, 16'h0, 16'h0002, 1'b0);
		chk_reg(1'b0, msr_pkg::SET_HIGH, 3'h0, 16'h0, 16'h0010, 1'b0);
		// a disabled passing test must not clear the bit
		limit.done = 4'h1;
		tick(1);
		limit = '0;
		tick(3);
		chk_reg(1'b0, msr_pkg::SET_LOW, 3'h0, 16'h0, 16'h0002, 1'b0);
		limit.done = 4'h1;
		limit.low_en = 4'h1;
		tick(1);
		limit = '0;
		tick(3);
		chk_reg(1'b0, msr_pkg::SET_LOW, 3'h0, 16'h0, 16'h0000, 1'b0);
		chk_reg(1'b0, msr_pkg::SET_LOW, 3'h1, 16'h0, 16'h0002, 1'b0);
		chk_reg(1'b0, msr_pkg::SET_LOW, 3'h1, 16'h0, 16'h0000, 1'b0);
		$display("test limits done");

		meas_busy = 2'h1;
		sensor_reading = 2'h2;
		calibrating_summary = 1'b1;
		tick(4);
		chk_reg(1'b0, msr_pkg::SET_MEAS, 3'h0, 16'h0, 16'h0002, 1'b0);
		chk_reg(1'b0, msr_pkg::SET_SENS, 3'h0, 16'h0, 16'h0004, 1'b0);
		chk_reg(1'b0, msr_pkg::SET_OPER, 3'h0, 16'h0, 16'h1411, 1'b0);
		chk_reg(1'b1, msr_pkg::SET_OPER, 3'h5, 16'h0, 16'h0, 1'b0);
		tick(3);
		chk_bit("operation summary", 1'b0, operation_summary);
		chk_reg(1'b0, msr_pkg::SET_MEAS, 3'h1, 16'h0, 16'h0002, 1'b0);
		meas_busy = 2'h0;
		sensor_reading = 2'h0;
		calibrating_summary = 1'b0;
		tick(3);
		chk_reg(1'b0, msr_pkg::SET_MEAS, 3'h0, 16'h0, 16'h0000, 1'b0);
		chk_reg(1'b0, msr_pkg::SET_SENS, 3'h0, 16'h0, 16'h0000, 1'b0);
		trig_enter_wait = 2'h2;
		tick(1);
		trig_enter_wait = 2'h0;
		tick(3);
		chk_reg(1'b0, msr_pkg::SET_TRIG, 3'h0, 16'h0, 16'h0004, 1'b0);
		trig_enter_idle = 2'h2;
		tick(1);
		trig_enter_idle = 2'h0;
		tick(3);
		chk_reg(1'b0, msr_pkg::SET_TRIG, 3'h0, 16'h0, 16'h0000, 1'b0);
		$display("test activity and preset done");

		chk_reg(1'b1, msr_pkg::SET_QUES, 3'h2, 16'h0200, 16'h0, 1'b0);
		cal_error = 2'h1;
		selftest_fail = 1'b1;
		power_summary = 1'b1;
		tick(1);
		cal_error = 2'h0;
		selftest_fail = 1'b0;
		tick(4);
		chk_reg(1'b0, msr_pkg::SET_CAL, 3'h0, 16'h0, 16'h0002, 1'b0);
		chk_reg(1'b0, msr_pkg::SET_QUES, 3'h0, 16'h0, 16'h0308, 1'b0);
		chk_bit("data quality summary", 1'b1, data_quality_out);
		cal_success = 2'h1;
		selftest_pass = 1'b1;
		power_summary = 1'b0;
		tick(1);
		cal_success = 2'h0;
		selftest_pass = 1'b0;
		tick(4);
		chk_reg(1'b0, msr_pkg::SET_CAL, 3'h0, 16'h0, 16'h0000, 1'b0);
		chk_reg(1'b0, msr_pkg::SET_CAL, 3'h1, 16'h0, 16'h0002, 1'b0);
		tick(2);
		chk_reg(1'b0, msr_pkg::SET_QUES, 3'h0, 16'h0, 16'h0000, 1'b0);
		$display("test data quality done");

		// reset in mid-run restores preset values
		chk_reg(1'b1, msr_pkg::SET_SENS, 3'h2, 16'h0001, 16'h0, 1'b0);
		arst_n = 1'b0;
		tick(2);
		chk_bit("answer in reset", 1'b0, rsp.valid);
		chk_bit("summary in reset", 1'b0, operation_summary | data_quality_out);
		arst_n = 1'b1;
		chk_reg(1'b0, msr_pkg::SET_SENS, 3'h2, 16'h0, 16'h7FFF, 1'b0);
		$display("test reset done");
		give_verdict;
	end
endmodule
